// File: core/vcd_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - Repaint whole screen fifty times per second.
// - Each cycle runs digital, then analog, then character mode.
// - Held reset while power-good low; starts in digital mode.
// - One flag per mode; exactly the current one high.
// - Fetch flag high while descriptions or character codes move.
// - Trace start fetches counts, start bit, loads 12-bit counter.
// - Scan bits; horizontal sweep held until start bit reached.
// - After the last bit of a word, fetch the next word.
// - Per bit bump both counters; all ones turns beam on/off.
// - Per bit bump horizontal count; bit drives vertical level.
// - Trace end resets horizontal, next line, next description.
// - Eighth trace bits drive intensity; bottom trace normal.
// - Analog blank word blanks trace unless all ones.
// - Analog entry loads address, drops one division, line one.
// - 200 bits per line; at 200 beam off, drop a tenth.
// - At 208 horizontal count returns to 1, next line.
// - Analog mode ends after 39 lines.
// - Character codes read via 8-bit counter and latched.
// - Code addresses stroke table; on, off or home moves.
// - 32 strokes per character, then move to next origin.
// - Codes 00 to 1f each select a fixed glyph; 00 blank.
// - Four characters on first seven lines, forty on bottom.
// - Code msb set shifts glyph down three thirty-seconds.
// - One DMA read per 8 us slot.
// - 8-bit counter cleared at each display cycle start.
// - Counter select picks 8-bit or 12-bit counter.
module vcd_sequencer
   import vcd_pkg::*;
#(
   parameter int FRAME_CYCLES = vcd_pkg::FRAME_CYC,
   parameter int SLOT_CYCLES = vcd_pkg::SLOT_CYC
)
(
   input wire logic mclk, // 125 MHz clock
   input wire logic rst_b, // Power-good reset, active low
   input wire logic dma_valid, // Read word returned
   input wire logic [7:0] dma_data, // Read word
   output logic dma_ready, // Room in the word buffer
   output vcd_pkg::vcd_dma_t dma, // DMA channel control
   output vcd_pkg::vcd_beam_t beam, // Beam drive
   output logic mode_digital, // Digital trace mode flag
   output logic mode_analog, // Analog trace mode flag
   output logic mode_char, // Character mode flag
   output logic fetch_active // Descriptor or code transfer
);
   import vcd_pkg::*;

   vcd_mode_t mode_r;
   vcd_phase_t phase_r;
   logic [7:0] buf_r [2];
   logic buf_wp_r, buf_rp_r, outst_r, drop_r, flush;
   logic [1:0] buf_cnt_r;
   logic [7:0] buf_head;
   logic take;
   logic [9:0] slot_r;
   logic [21:0] frame_r;
   logic frame_pend_r;
   logic [2:0] desc_idx_r;
   logic [7:0] unb_r, blk_r, ubc_r, bkc_r, addr_lo_r, word_r, code_r;
   logic [2:0] start_bit_r, bit_r;
   logic have_r, x_en_r, beam_r, ana_ok_r;
   logic [3:0] trace_r;
   logic [5:0] cidx_r;
   logic [4:0] stroke_r;
   logic [7:0] x_nxt;
   logic [2:0] ubit;

   // ---------------------------------------------------------------
   // Two-entry word buffer
   // ---------------------------------------------------------------
   // The channel waits while the buffer is full, so a slow bit path
   // never loses a word the channel already delivered.
   assign dma_ready = (buf_cnt_r != 2'h2);
   assign buf_head = buf_r[buf_rp_r];
   always_ff @(posedge mclk)
   begin
      if (!rst_b || flush)
      begin
         buf_wp_r <= 1'b0;
         buf_rp_r <= 1'b0;
         buf_cnt_r <= 2'h0;
      end
      else
      begin
         if (dma_valid && dma_ready && !drop_r)
         begin
            buf_r[buf_wp_r] <= dma_data;
            buf_wp_r <= ~buf_wp_r;
         end
         if (take)
            buf_rp_r <= ~buf_rp_r;
         buf_cnt_r <= buf_cnt_r + 2'((dma_valid && dma_ready && !drop_r) ? 1 : 0)
                    - 2'(take ? 1 : 0);
      end
   end

   // ---------------------------------------------------------------
   // DMA slot pacing and counter control
   // ---------------------------------------------------------------
   logic want;
   assign want = (phase_r == PH_DESC) || (phase_r == PH_CODE) || (phase_r == PH_DATA);
   assign fetch_active = (phase_r == PH_DESC) || (phase_r == PH_CODE);
   // Slot counter is 10 bits: periods above 1024 cycles need it widened
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         slot_r <= 10'h0;
      else if (slot_r == 10'(SLOT_CYCLES - 1))
         slot_r <= 10'h0;
      else
         slot_r <= slot_r + 10'h1;
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         outst_r <= 1'b0;
         drop_r <= 1'b0;
         dma <= '{req: 1'b0, sel: 1'b0, clr8: 1'b1, load12: 1'b0, load_addr: 12'h0};
      end
      else
      begin
         // A reply still in flight across a flush belongs to the old trace
         if (dma_valid)
            outst_r <= 1'b0;
         if (dma_valid)
            drop_r <= 1'b0;
         else if (flush && outst_r)
            drop_r <= 1'b1;
         dma.req <= 1'b0;
         dma.clr8 <= 1'b0;
         dma.load12 <= 1'b0;
         if (slot_r == 10'(SLOT_CYCLES - 1) && want && !outst_r && !flush
             && buf_cnt_r == 2'h0 && !(dma.load12 || dma.clr8))
         begin
            dma.req <= 1'b1;
            outst_r <= 1'b1;
         end
         dma.sel <= (phase_r == PH_DATA);
         if (phase_r == PH_IDLE && frame_pend_r)
            dma.clr8 <= 1'b1;
         if (take && phase_r == PH_DESC &&
             desc_idx_r == 3'((mode_r == VCD_DIG) ? DESC_DIG - 1 : DESC_ANA - 1))
         begin
            dma.load12 <= 1'b1;
            dma.load_addr <= {buf_head[3:0], addr_lo_r};
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame timer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         frame_r <= 22'h0;
         frame_pend_r <= 1'b0;
      end
      else
      begin
         frame_r <= (frame_r == 22'(FRAME_CYCLES - 1)) ? 22'h0 : frame_r + 22'h1;
         // A tick in the restart cycle is kept: set wins over clear
         if (frame_r == 22'(FRAME_CYCLES - 1))
            frame_pend_r <= 1'b1;
         else if (phase_r == PH_IDLE)
            frame_pend_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Stroke table
   // ---------------------------------------------------------------
   // Returns {move, on, home, dir}; code 00 never lights the beam.
   function automatic logic [5:0] stroke_of(input logic [4:0] code, input logic [4:0] s);
      logic on;
      logic [2:0] dir;
      on = (code != 5'h0) && (^(code & s) | (code[0] & s[0]));
      dir = s[2:0] + code[2:0];
      if (!on && dir == 3'h7)
         dir = 3'h0;
      if (s == 5'(STROKES - 1))
         stroke_of = {3'b001, 3'h0};
      else
         stroke_of = {1'b1, on, 1'b0, dir};
   endfunction

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   assign mode_digital = mode_r[0];
   assign mode_analog = mode_r[1];
   assign mode_char = mode_r[2];
   assign ubit = bit_r;

   always_comb
   begin
      take = 1'b0;
      flush = 1'b0;
      case (phase_r)
         PH_DESC, PH_CODE: take = (buf_cnt_r != 2'h0);
         PH_DATA:
         begin
            take = !have_r && (buf_cnt_r != 2'h0) &&
                   !(mode_r == VCD_ANA && beam.x_count > 8'(ANA_BITS));
            flush = (mode_r == VCD_DIG && beam.x_count == 8'(TRACE_BITS)) ||
                    (mode_r == VCD_ANA && beam.x_count == 8'(ANA_WRAP) &&
                     cidx_r == 6'(ANA_LINES - 1));
         end
         default: ;
      endcase
   end
   assign x_nxt = beam.x_count + 8'h1;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         mode_r <= VCD_DIG;
         phase_r <= PH_DESC;
         desc_idx_r <= 3'h0;
         {unb_r, blk_r, ubc_r, bkc_r, addr_lo_r, word_r, code_r} <= '0;
         {start_bit_r, bit_r} <= 6'h0;
         {have_r, x_en_r, beam_r, ana_ok_r} <= 4'h0;
         trace_r <= 4'h0;
         cidx_r <= 6'h0;
         stroke_r <= 5'h0;
         beam <= '0;
      end
      else
      begin
         beam.x_ramp_rst <= 1'b0;
         beam.stroke_move <= 1'b0;
         beam.stroke_home <= 1'b0;
         if (take && phase_r == PH_DATA)
         begin
            word_r <= buf_head;
            have_r <= 1'b1;
            bit_r <= 3'h0;
         end
         case (phase_r)
            PH_DESC:
            begin
               beam.z_on <= 1'b0;
               if (take)
               begin
                  desc_idx_r <= desc_idx_r + 3'h1;
                  case (desc_idx_r)
                     3'h0: unb_r <= buf_head;
                     3'h1: blk_r <= buf_head;
                     default: ;
                  endcase
                  if (mode_r == VCD_DIG)
                  begin
                     if (desc_idx_r == 3'h2)
                        start_bit_r <= buf_head[2:0];
                     if (desc_idx_r == 3'h3)
                        addr_lo_r <= buf_head;
                  end
                  else if (desc_idx_r == 3'h2)
                     addr_lo_r <= buf_head;
                  if (desc_idx_r == 3'((mode_r == VCD_DIG) ? DESC_DIG - 1 : DESC_ANA - 1))
                  begin
                     phase_r <= PH_DATA;
                     desc_idx_r <= 3'h0;
                     ubc_r <= unb_r;
                     bkc_r <= blk_r;
                     x_en_r <= 1'b0;
                     beam_r <= 1'b0;
                     beam.x_count <= (mode_r == VCD_ANA) ? 8'h1 : 8'h0;
                     beam.x_ramp_rst <= 1'b1;
                     if (mode_r == VCD_ANA)
                     begin
                        ana_ok_r <= (blk_r == ALL_ONES);
                        beam.y_ana <= 6'h1;
                        cidx_r <= 6'h0;
                     end
                  end
               end
            end
            PH_DATA:
            begin
               if (mode_r == VCD_DIG && have_r)
               begin
                  have_r <= (bit_r != BIT_LAST) || take;
                  bit_r <= bit_r + 3'h1;
                  ubc_r <= ubc_r + 8'h1;
                  bkc_r <= bkc_r + 8'h1;
                  if (ubc_r == ALL_ONES)
                     beam_r <= 1'b1;
                  else if (bkc_r == ALL_ONES)
                     beam_r <= 1'b0;
                  if (x_en_r || bit_r == start_bit_r)
                  begin
                     x_en_r <= 1'b1;
                     beam.x_count <= x_nxt;
                     if (trace_r == 4'(UNDERLINE_TRACE))
                        beam.z_on <= beam_r & word_r[ubit];
                     else
                     begin
                        beam.y_bit <= word_r[ubit];
                        beam.z_on <= beam_r;
                     end
                  end
               end
               if (mode_r == VCD_DIG && beam.x_count == 8'(TRACE_BITS))
               begin
                  beam.x_count <= 8'h0;
                  beam.x_ramp_rst <= 1'b1;
                  beam.z_on <= 1'b0;
                  have_r <= 1'b0;
                  beam.y_line <= beam.y_line + 4'h1;
                  trace_r <= trace_r + 4'h1;
                  phase_r <= PH_DESC;
                  if (trace_r == 4'(DIG_TRACES - 1))
                  begin
                     mode_r <= VCD_ANA;
                     trace_r <= 4'h0;
                  end
               end
               if (mode_r == VCD_ANA)
               begin
                  if (beam.x_count <= 8'(ANA_BITS))
                  begin
                     if (have_r)
                     begin
                        have_r <= (bit_r != BIT_LAST) || take;
                        bit_r <= bit_r + 3'h1;
                        beam.z_on <= ana_ok_r & word_r[ubit];
                        beam.x_count <= x_nxt;
                        if (beam.x_count == 8'(ANA_BITS))
                        begin
                           beam.z_on <= 1'b0;
                           beam.x_ramp_rst <= 1'b1;
                           beam.y_ana <= beam.y_ana + 6'h1;
                        end
                     end
                  end
                  else if (beam.x_count == 8'(ANA_WRAP))
                  begin
                     beam.x_count <= 8'h1;
                     cidx_r <= cidx_r + 6'h1;
                     if (cidx_r == 6'(ANA_LINES - 1))
                     begin
                        mode_r <= VCD_CHR;
                        phase_r <= PH_CODE;
                        cidx_r <= 6'h0;
                        have_r <= 1'b0;
                        beam.x_count <= 8'h0;
                        beam.y_line <= 4'h0;
                     end
                  end
                  else
                     beam.x_count <= x_nxt;
               end
            end
            PH_CODE:
            begin
               beam.z_on <= 1'b0;
               if (take)
               begin
                  code_r <= buf_head;
                  beam.y_shift <= buf_head[7];
                  stroke_r <= 5'h0;
                  phase_r <= PH_STROKE;
               end
            end
            PH_STROKE:
            begin
               {beam.stroke_move, beam.z_on, beam.stroke_home, beam.stroke_dir}
                  <= stroke_of(code_r[4:0], stroke_r);
               stroke_r <= stroke_r + 5'h1;
               if (stroke_r == 5'(STROKES - 1))
               begin
                  beam.z_on <= 1'b0;
                  beam.x_count <= {2'h0, cidx_r} + 8'h1;
                  cidx_r <= cidx_r + 6'h1;
                  phase_r <= PH_CODE;
                  if (cidx_r == 6'((beam.y_line == 4'(CHR_LINES - 1)) ?
                                   CHR_LONG - 1 : CHR_SHORT - 1))
                  begin
                     cidx_r <= 6'h0;
                     beam.x_count <= 8'h0;
                     beam.y_line <= beam.y_line + 4'h1;
                     if (beam.y_line == 4'(CHR_LINES - 1))
                        phase_r <= PH_IDLE;
                  end
               end
            end
            PH_IDLE:
            begin
               beam.z_on <= 1'b0;
               if (frame_pend_r)
               begin
                  mode_r <= VCD_DIG;
                  phase_r <= PH_DESC;
                  beam.y_line <= 4'h0;
                  beam.y_shift <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_onehot;
      @(posedge mclk) disable iff (!rst_b) $onehot({mode_digital, mode_analog, mode_char});
   endproperty
   a_onehot: assert property (p_onehot) else $error("mode flags not one-hot");
   property p_order;
      @(posedge mclk) disable iff (!rst_b)
         $changed(mode_r) |-> (mode_r == VCD_ANA && $past(mode_r) == VCD_DIG) ||
            (mode_r == VCD_CHR && $past(mode_r) == VCD_ANA) ||
            (mode_r == VCD_DIG && $past(mode_r) == VCD_CHR);
   endproperty
   a_order: assert property (p_order) else $error("mode order broken");
   property p_fetch;
      @(posedge mclk) disable iff (!rst_b) dma.req && !dma.sel |-> $past(fetch_active);
   endproperty
   a_fetch: assert property (p_fetch) else $error("byte fetch outside fetch flag");
   property p_slot;
      @(posedge mclk) disable iff (!rst_b) dma.req |=> !dma.req [*8];
   endproperty
   a_slot: assert property (p_slot) else $error("requests too close");
   property p_dark;
      @(posedge mclk) disable iff (!rst_b) phase_r == PH_DESC |=> !beam.z_on;
   endproperty
   a_dark: assert property (p_dark) else $error("beam lit while fetching");
   property p_wrap;
      @(posedge mclk) disable iff (!rst_b)
         mode_analog && phase_r == PH_DATA && beam.x_count == 8'(ANA_WRAP)
         |=> beam.x_count == 8'h1 || mode_char;
   endproperty
   a_wrap: assert property (p_wrap) else $error("analog wrap wrong");
   property p_blank;
      @(posedge mclk) disable iff (!rst_b) mode_analog && !ana_ok_r |=> !beam.z_on;
   endproperty
   a_blank: assert property (p_blank) else $error("blanked analog trace lit");
   property p_clear;
      @(posedge mclk) disable iff (!rst_b)
         phase_r == PH_IDLE && frame_pend_r |=> dma.clr8 && mode_digital;
   endproperty
   a_clear: assert property (p_clear) else $error("cycle start without clear");
   property p_under;
      @(posedge mclk) disable iff (!rst_b)
         mode_digital && trace_r == 4'(UNDERLINE_TRACE) && phase_r == PH_DATA
         |=> $stable(beam.y_bit);
   endproperty
   a_under: assert property (p_under) else $error("underline trace moved vertical");
endmodule

// File: core/vcd_pkg.sv
package vcd_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int SLOT_US = 8;
   localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
   localparam int FRAME_HZ = 50;
   localparam int FRAME_CYC = (CLK_MHZ * 1000000) / FRAME_HZ;
   // ---------------------------------------------------------------
   // Display geometry
   // ---------------------------------------------------------------
   localparam int DIG_TRACES = 9;
   localparam int UNDERLINE_TRACE = 7;
   localparam int TRACE_BITS = 200;
   localparam int ANA_BITS = 200;
   localparam int ANA_WRAP = 208;
   localparam int ANA_LINES = 39;
   localparam int STROKES = 32;
   localparam int CHR_LINES = 8;
   localparam int CHR_SHORT = 4;
   localparam int CHR_LONG = 40;
   localparam int DESC_DIG = 5;
   localparam int DESC_ANA = 4;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      VCD_DIG = 3'b001,
      VCD_ANA = 3'b010,
      VCD_CHR = 3'b100
   } vcd_mode_t;
   typedef enum logic [4:0] {
      PH_DESC = 5'b00001,
      PH_DATA = 5'b00010,
      PH_CODE = 5'b00100,
      PH_STROKE = 5'b01000,
      PH_IDLE = 5'b10000
   } vcd_phase_t;
   typedef struct packed {
      logic req;
      logic sel;
      logic clr8;
      logic load12;
      logic [11:0] load_addr;
   } vcd_dma_t;
   typedef struct packed {
      logic [7:0] x_count;
      logic x_ramp_rst;
      logic [3:0] y_line;
      logic y_bit;
      logic [5:0] y_ana;
      logic y_shift;
      logic z_on;
      logic [2:0] stroke_dir;
      logic stroke_move;
      logic stroke_home;
   } vcd_beam_t;
endpackage

// File: verification/vcd_dma_ram.sv
`timescale 1ns/1ps
module vcd_dma_ram
   import vcd_pkg::*;
(
   input wire logic mclk, // Clock
   input vcd_pkg::vcd_dma_t dma, // Channel control
   input wire logic dma_ready, // Buffer room
   input wire logic slow, // Answer late when high
   output logic dma_valid, // Read word strobe
   output logic [7:0] dma_data // Read word
);
   logic [7:0] cnt8_r;
   logic [11:0] cnt12_r;
   logic pend_r;
   logic sel_r;
   int wait_r;
   // Control bytes: two digital descriptors back to back
   function automatic logic [7:0] ctl_byte(input logic [7:0] a);
      case (a)
         8'h00, 8'h05: return 8'hf8;
         8'h02, 8'h07: return 8'h03;
         8'h03: return 8'h10;
         8'h08: return 8'h40;
         8'h04, 8'h09: return 8'h02;
         default: return 8'h00;
      endcase
   endfunction
   initial
   begin
      cnt8_r = 8'h00;
      cnt12_r = 12'h000;
      pend_r = 1'b0;
      sel_r = 1'b0;
      wait_r = 0;
      dma_valid = 1'b0;
      dma_data = 8'h5a;
   end
   // Idle data line toggles so a stale word never looks valid
   always @(negedge mclk)
   begin
      dma_valid <= 1'b0;
      dma_data <= ~dma_data;
      if (dma.clr8) cnt8_r <= 8'h00;
      if (dma.load12) cnt12_r <= dma.load_addr;
      if (dma.req && !pend_r)
      begin
         pend_r <= 1'b1;
         sel_r <= dma.sel;
         wait_r <= slow ? 300 : 1;
      end
      else if (pend_r && wait_r > 0) wait_r <= wait_r - 1;
      else if (pend_r && dma_ready)
      begin
         pend_r <= 1'b0;
         dma_valid <= 1'b1;
         if (sel_r)
         begin
            dma_data <= cnt12_r[0] ? 8'h00 : 8'hff;
            cnt12_r <= cnt12_r + 12'h001;
         end
         else
         begin
            dma_data <= ctl_byte(cnt8_r);
            cnt8_r <= cnt8_r + 8'h01;
         end
      end
   end
endmodule

// File: verification/vcd_sequencer_tb.sv
`timescale 1ns/1ps
module vcd_sequencer_tb;
   import vcd_pkg::*;
   // Short slot so one whole display cycle fits in the run
   localparam int FRAME_SIM = 40000;
   localparam int SLOT_SIM = 16;
   logic mclk, rst_b, slow, dma_valid, dma_ready;
   logic mode_digital, mode_analog, mode_char, fetch_active;
   logic [7:0] dma_data;
   vcd_dma_t dma;
   vcd_beam_t beam;
   int error_cnt = 0;
   int samples_checked = 0;
   int since_req = 0;
   bit seen_req = 0;
   time rel_t = 0;
   vcd_sequencer #(.FRAME_CYCLES(FRAME_SIM), .SLOT_CYCLES(SLOT_SIM))
      vcd_sequencer_inst (.mclk(mclk), .rst_b(rst_b),
      .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready), .dma(dma),
      .beam(beam), .mode_digital(mode_digital), .mode_analog(mode_analog),
      .mode_char(mode_char), .fetch_active(fetch_active));
   vcd_dma_ram vcd_dma_ram_inst (.mclk(mclk), .dma(dma), .dma_ready(dma_ready),
      .slow(slow), .dma_valid(dma_valid), .dma_data(dma_data));
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ---------------------------------------------------------------
   // Compare and report
   // ---------------------------------------------------------------
   task automatic chk_bit(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_vec(input string what, input logic [11:0] exp, input logic [11:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Mode flags one-hot and slot pacing watched all along
   always @(negedge mclk)
   begin
      since_req <= since_req + 1;
      if (rst_b !== 1'b1)
         seen_req <= 1'b0;
      else
      begin
         chk_bit("one hot", 1'b1, $onehot({mode_digital, mode_analog, mode_char}));
         if (dma.req === 1'b1)
         begin
            if (seen_req) chk_bit("slot", 1'b1, since_req >= SLOT_SIM);
            seen_req <= 1'b1;
            since_req <= 1;
         end
      end
   end
   initial
   begin
      // A full run needs about 41k cycles
      repeat (60000) @(posedge mclk);
      error_cnt++;
      $display("mismatch watchdog expected done seen timeout");
      tally_and_finish;
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic held_reset(input int n);
      rst_b = 1'b0;
      repeat (n) @(negedge mclk);
      chk_bit("rst digital", 1'b1, mode_digital);
      chk_bit("rst fetch", 1'b1, fetch_active);
      chk_bit("rst clr8", 1'b1, dma.clr8);
      chk_bit("rst req", 1'b0, dma.req);
      chk_bit("rst beam", 1'b0, beam.z_on);
      rst_b = 1'b1;
      rel_t = $time;
      repeat (2) @(negedge mclk);
      chk_bit("run digital", 1'b1, mode_digital);
      chk_bit("clr8 drop", 1'b0, dma.clr8);
   endtask
   task automatic wait_load(input logic [11:0] exp);
      int n;
      n = 0;
      while (dma.load12 !== 1'b1 && n < 7000)
      begin
         @(negedge mclk);
         if (dma.req === 1'b1)
         begin
            chk_bit("desc sel", 1'b0, dma.sel);
            chk_bit("desc fetch", 1'b1, fetch_active);
         end
         n++;
      end
      chk_vec("load addr", exp, dma.load_addr);
   endtask
   task automatic wait_word;
      int n;
      n = 0;
      while (dma_valid !== 1'b1 && n < 2500)
      begin
         @(negedge mclk);
         n++;
      end
      chk_bit("data sel", 1'b1, dma.sel);
      chk_bit("data fetch", 1'b0, fetch_active);
      @(negedge mclk);
   endtask
   task automatic t_trace;
      int n;
      wait_load(12'h210);
      wait_word;
      repeat (14) @(negedge mclk);
      chk_vec("x after word1", 12'h005, {4'h0, beam.x_count});
      chk_bit("y word1", 1'b1, beam.y_bit);
      wait_word;
      repeat (14) @(negedge mclk);
      chk_vec("x after word2", 12'h00d, {4'h0, beam.x_count});
      chk_bit("y word2", 1'b0, beam.y_bit);
      chk_bit("beam on", 1'b1, beam.z_on);
      n = 0;
      while (beam.y_line !== 4'h1 && n < 32000)
      begin
         @(negedge mclk);
         n++;
      end
      repeat (2) @(negedge mclk);
      chk_vec("x at trace end", 12'h000, {4'h0, beam.x_count});
      chk_bit("dark retrace", 1'b0, beam.z_on);
      wait_load(12'h240);
   endtask
   task automatic t_mid_reset;
      wait_word;
      repeat (3) @(negedge mclk);
      slow = 1'b1;
      held_reset(3);
      wait_load(12'h210);
   endtask
   // Rest of the display cycle: descriptors beyond the first two and all
   // character codes read as zero, so analog stays blanked and glyphs blank
   task automatic t_cycle;
      int n, lit, ramps, homes;
      n = 0;
      lit = 0;
      ramps = 0;
      homes = 0;
      slow = 1'b0;
      while (mode_analog !== 1'b1 && n < 20000)
      begin
         @(negedge mclk);
         n++;
      end
      chk_vec("traces", 12'(DIG_TRACES), {8'h0, beam.y_line});
      chk_bit("ana fetch", 1'b1, fetch_active);
      wait_load(12'h000);
      chk_vec("ana drop", 12'h001, {6'h0, beam.y_ana});
      chk_vec("ana x", 12'h001, {4'h0, beam.x_count});
      n = 0;
      while (mode_char !== 1'b1 && n < 30000)
      begin
         @(negedge mclk);
         lit += (beam.z_on === 1'b1);
         ramps += (beam.x_ramp_rst === 1'b1);
         n++;
      end
      chk_vec("ana lit", 12'h000, 12'(lit));
      chk_vec("ana lines", 12'(ANA_LINES), 12'(ramps));
      chk_vec("ana end drop", 12'(ANA_LINES + 1), {6'h0, beam.y_ana});
      chk_bit("chr fetch", 1'b1, fetch_active);
      n = 0;
      while (mode_digital !== 1'b1 && n < 40000)
      begin
         @(negedge mclk);
         lit += (beam.z_on === 1'b1);
         homes += (beam.stroke_home === 1'b1);
         n++;
      end
      chk_vec("chr lit", 12'h000, 12'(lit));
      chk_vec("chr count", 12'((CHR_LINES - 1) * CHR_SHORT + CHR_LONG), 12'(homes));
      chk_bit("cycle clr8", 1'b1, dma.clr8);
      chk_bit("frame period", 1'b1, ($time - rel_t) / 8 == FRAME_SIM + 1);
   endtask
   initial
   begin
      rst_b = 1'b0;
      slow = 1'b0;
      held_reset(12);
      t_trace;
      t_mid_reset;
      t_cycle;
      tally_and_finish;
   end
endmodule
